// file: design/tlsa_core.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// [RULE_01] Data register drives data pin, reads pad
// [RULE_02] Clock register drives clock pin, reads pad
// [RULE_03] Open-drain outputs; readback shows external level
// [RULE_04] Enable bit hands pins to block, resets 0
// [RULE_05] Data fall while clock high sets flag one
// [RULE_06] Data rise while clock high sets flag two
// [RULE_07] Condition flags read-only, cleared by write
// [RULE_08] Flags raise interrupts at bits 7 and 6
// [RULE_09] Detectors run regardless of transfer direction
// [RULE_10] Unconditional stretch holds clock low after fall
// [RULE_11] Sampled-data write clears wait, releases clock
// [RULE_12] Conditional stretch when flag one already set
// [RULE_13] Clock rising edge captures data into sample
// [RULE_14] Edge flag set on sample, cleared by read
// [RULE_15] Wait flag at bit 3, upper bits zero
// [RULE_16] Software uses interrupt or polls the flags
// [RULE_17] Software enables pull-ups without external ones
// [RULE_18] Enabled block takes port B lines four, five
// [RULE_19] Pads synchronised, edges from synchronised values
module tlsa_core (
   // Clock, reset and freeze
   input  wire logic       sys_clk,
   input  wire logic       rstn,
   input  wire logic       clk_en,
   // Register port
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   // Port B line four, serial clock line
   input  wire logic       port_b_line_four_in,
   output logic            port_b_line_four_out,
   output logic            port_b_line_four_oe,
   // Port B line five, serial data line
   input  wire logic       port_b_line_five_in,
   output logic            port_b_line_five_out,
   output logic            port_b_line_five_oe,
   // Pin ownership and interrupt
   output logic            block_owns_pins,
   output logic            irq
);
   import tlsa_pkg::*;

   logic       data_out_bit;                 // Stored data drive value
   logic       clock_out_bit;                // Stored clock drive value
   logic       block_enable;                 // Block owns the two lines
   logic       unconditional_stretch_enable; // Stretch after every fall
   logic       conditional_stretch_enable;   // Stretch after fall once flag one set
   logic       stretch_active_flag;          // Clock held low by the block
   logic       falling_condition_bit;        // Condition one seen
   logic       rising_condition_bit;         // Condition two seen
   logic       sampled_data_value;           // Data at last clock rise
   logic       new_sample_flag;              // Unread sample present
   logic [1:0] irq_status;                   // Sticky interrupt bits, fall and rise
   logic [1:0] irq_enable;                   // Interrupt enable bits
   logic [1:0] clk_sync;                     // Clock pad synchroniser
   logic [1:0] dat_sync;                     // Data pad synchroniser
   logic       clk_prev;                     // Previous synced clock
   logic       dat_prev;                     // Previous synced data
   logic       serial_clock_line;            // Synced clock level
   logic       serial_data_line;             // Synced data level
   logic       clk_rise;                     // Clock rising edge
   logic       clk_fall;                     // Clock falling edge
   logic       dat_rise;                     // Data rising edge
   logic       dat_fall;                     // Data falling edge
   logic       cond_one_evt;                 // Condition one event
   logic       cond_two_evt;                 // Condition two event
   logic       stretch_evt;                  // Start of stretching
   logic       wr_sampled;                   // Write to sampled-data register
   logic [7:0] next_rdata;                   // Read mux result

   // Decode of a register hit, shared by write and read paths
   function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
      hit = (a == r);
   endfunction

   assign serial_clock_line = clk_sync[1];
   assign serial_data_line  = dat_sync[1];

   // Two-stage synchronisers for both pads
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         clk_sync <= 2'h3;
         dat_sync <= 2'h3;
      end else if (clk_en) begin
         clk_sync <= {clk_sync[0], port_b_line_four_in}; // see [RULE_19]
         dat_sync <= {dat_sync[0], port_b_line_five_in}; // see [RULE_19]
      end
   end

   // Previous synced levels for edge detection
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         clk_prev <= 1'h1;
         dat_prev <= 1'h1;
      end else if (clk_en) begin
         clk_prev <= serial_clock_line;
         dat_prev <= serial_data_line;
      end
   end

   // Edges taken from synchronised values only
   assign clk_rise = serial_clock_line & ~clk_prev;   // see [RULE_19]
   assign clk_fall = ~serial_clock_line & clk_prev;
   assign dat_rise = serial_data_line & ~dat_prev;
   assign dat_fall = ~serial_data_line & dat_prev;

   // Conditions: data edge while clock high, no direction gating
   assign cond_one_evt = block_enable & dat_fall & clk_prev;  // see [RULE_05] see [RULE_09]
   assign cond_two_evt = block_enable & dat_rise & clk_prev;  // see [RULE_06] see [RULE_09]

   // Stretch starts on a clock fall when either stretch mode applies
   assign stretch_evt = block_enable & clk_fall &
                        (unconditional_stretch_enable |                    // see [RULE_10]
                         (conditional_stretch_enable & falling_condition_bit)); // see [RULE_12]

   assign wr_sampled = reg_wr & hit(reg_addr, ADDR_SAMPLED);

   // Drive value registers
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         data_out_bit  <= DRIVE_RESET;                      // see [RULE_01]
         clock_out_bit <= DRIVE_RESET;                      // see [RULE_02]
      end else if (clk_en && reg_wr) begin
         if (hit(reg_addr, ADDR_DATA_LINE)) begin
            data_out_bit <= reg_wdata[0];                   // see [RULE_01]
         end
         if (hit(reg_addr, ADDR_CLOCK_LINE)) begin
            clock_out_bit <= reg_wdata[0];                  // see [RULE_02]
         end
      end
   end

   // Control register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         {conditional_stretch_enable, unconditional_stretch_enable, block_enable} <= CTRL_RESET; // see [RULE_04]
      end else if (clk_en && reg_wr && hit(reg_addr, ADDR_CONTROL)) begin
         block_enable                 <= reg_wdata[CTRL_ENABLE_BIT];
         unconditional_stretch_enable <= reg_wdata[CTRL_UNCOND_BIT];
         conditional_stretch_enable   <= reg_wdata[CTRL_COND_BIT];
      end
   end

   // Wait flag: set on stretch start, set wins over release write
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         stretch_active_flag <= 1'h0;
      end else if (clk_en) begin
         if (stretch_evt) begin
            stretch_active_flag <= 1'h1;                    // see [RULE_10] see [RULE_12]
         end else if (wr_sampled || !block_enable) begin
            stretch_active_flag <= 1'h0;                    // see [RULE_11]
         end
      end
   end

   // Condition flags: set wins over the write clear
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         falling_condition_bit <= 1'h0;
         rising_condition_bit  <= 1'h0;
      end else if (clk_en) begin
         if (cond_one_evt) begin
            falling_condition_bit <= 1'h1;
         end else if (reg_wr && hit(reg_addr, ADDR_FALL_COND)) begin
            falling_condition_bit <= 1'h0;                  // see [RULE_07]
         end
         if (cond_two_evt) begin
            rising_condition_bit <= 1'h1;
         end else if (reg_wr && hit(reg_addr, ADDR_RISE_COND)) begin
            rising_condition_bit <= 1'h0;                   // see [RULE_07]
         end
      end
   end

   // Sample capture and unread flag
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         sampled_data_value <= 1'h0;
         new_sample_flag    <= 1'h0;
      end else if (clk_en) begin
         if (block_enable && clk_rise) begin
            sampled_data_value <= serial_data_line;         // see [RULE_13]
            new_sample_flag    <= 1'h1;                     // see [RULE_14]
         end else if (reg_rd && hit(reg_addr, ADDR_SAMPLED)) begin
            new_sample_flag <= 1'h0;                        // see [RULE_14]
         end
      end
   end

   // Interrupt status, enable and clear
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         irq_status <= 2'h0;
         irq_enable <= 2'h0;
      end else if (clk_en) begin
         if (reg_wr && hit(reg_addr, ADDR_IRQ_ENABLE)) begin
            irq_enable <= {reg_wdata[IRQ_FALL_BIT], reg_wdata[IRQ_RISE_BIT]};
         end
         for (int i = 0; i < 2; i++) begin
            if ((i == 1) ? cond_one_evt : cond_two_evt) begin
               irq_status[i] <= 1'h1;                       // see [RULE_08]
            end else if (reg_wr && hit(reg_addr, ADDR_IRQ_CLEAR) &&
                         reg_wdata[(i == 1) ? IRQ_FALL_BIT : IRQ_RISE_BIT]) begin
               irq_status[i] <= 1'h0;
            end
         end
      end
   end

   assign irq = |(irq_status & irq_enable);                // see [RULE_08]

   // Open-drain pads: enable high only when pulling low
   assign block_owns_pins      = block_enable;              // see [RULE_18]
   assign port_b_line_four_out = 1'h0;
   assign port_b_line_five_out = 1'h0;
   assign port_b_line_four_oe  = block_enable &
                                 (~clock_out_bit | stretch_active_flag); // see [RULE_03] see [RULE_10]
   assign port_b_line_five_oe  = block_enable & ~data_out_bit;           // see [RULE_03]

   // Read mux; line registers return pad levels
   always_comb begin
      next_rdata = 8'h00;
      case (reg_addr)
         ADDR_DATA_LINE:  next_rdata[0] = serial_data_line;   // see [RULE_01] see [RULE_03]
         ADDR_CLOCK_LINE: next_rdata[0] = serial_clock_line;  // see [RULE_02] see [RULE_03]
         ADDR_CONTROL:    next_rdata[3:0] = {stretch_active_flag, conditional_stretch_enable,
                                             unconditional_stretch_enable, block_enable}; // see [RULE_15]
         ADDR_FALL_COND:  next_rdata[0] = falling_condition_bit;
         ADDR_RISE_COND:  next_rdata[0] = rising_condition_bit;
         ADDR_SAMPLED:    next_rdata[0] = sampled_data_value;
         ADDR_EDGE_FLAG:  next_rdata[0] = new_sample_flag;
         ADDR_IRQ_STATUS: next_rdata[IRQ_FALL_BIT:IRQ_RISE_BIT] = irq_status;
         ADDR_IRQ_ENABLE: next_rdata[IRQ_FALL_BIT:IRQ_RISE_BIT] = irq_enable;
         default:         next_rdata = 8'h00;
      endcase
   end

   // Read data register, valid the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= reg_rd ? next_rdata : 8'h00;
      end
   end

   // Checks
   chk_fall_cond_set: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_05]
      clk_en && cond_one_evt |=> falling_condition_bit)
      else $error("condition one not flagged");
   chk_rise_cond_set: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_06]
      clk_en && cond_two_evt |=> rising_condition_bit)
      else $error("condition two not flagged");
   chk_cond_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_07]
      clk_en && reg_wr && hit(reg_addr, ADDR_FALL_COND) && !cond_one_evt
      |=> !falling_condition_bit)
      else $error("condition one not cleared by write");
   chk_irq_level: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_08]
      $rose(irq_status[1]) && irq_enable[1] |-> irq)
      else $error("enabled interrupt not raised");
   chk_stretch_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_10]
      clk_en && stretch_evt |=> stretch_active_flag && port_b_line_four_oe)
      else $error("clock not held low");
   chk_release_write: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_11]
      clk_en && wr_sampled && !stretch_evt |=> !stretch_active_flag)
      else $error("stretch not released");
   chk_sample_cap: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_13]
      clk_en && block_enable && clk_rise
      |=> sampled_data_value == $past(serial_data_line) && new_sample_flag)
      else $error("sample not captured");
   chk_ctrl_upper: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_15]
      clk_en && reg_rd && hit(reg_addr, ADDR_CONTROL)
      |=> reg_rdata[7:4] == 4'h0 && reg_rdata[3] == $past(stretch_active_flag))
      else $error("control readback wrong");
   chk_data_readback: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_01]
      clk_en && reg_rd && hit(reg_addr, ADDR_DATA_LINE)
      |=> reg_rdata == {7'h00, $past(serial_data_line)})
      else $error("data readback not from pad");

   // Clock register returns the synced pad level, not the stored bit
   chk_clock_readback: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_02]
      clk_en && reg_rd && hit(reg_addr, ADDR_CLOCK_LINE)
      |=> reg_rdata == {7'h00, $past(serial_clock_line)})
      else $error("clock readback not from pad");

   // Second condition flag drops on a write to its own index
   chk_rise_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_07]
      clk_en && reg_wr && hit(reg_addr, ADDR_RISE_COND) && !cond_two_evt
      |=> !rising_condition_bit)
      else $error("condition two not cleared by write");

   // Conditional stretch starts only once flag one is already set
   chk_cond_stretch: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_12]
      clk_en && block_enable && clk_fall && conditional_stretch_enable && falling_condition_bit
      |=> stretch_active_flag)
      else $error("conditional stretch missed");

   // Reading the sampled bit clears the unread mark unless a new sample lands
   chk_edge_clear: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_14]
      clk_en && reg_rd && hit(reg_addr, ADDR_SAMPLED) && !(block_enable && clk_rise)
      |=> !new_sample_flag)
      else $error("unread mark not cleared");

   // Disabled block neither pulls a line nor detects a condition
   chk_disabled_idle: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_04]
      !block_enable
      |-> !port_b_line_four_oe && !port_b_line_five_oe && !cond_one_evt && !cond_two_evt)
      else $error("disabled block still active");

   // A stored zero pulls the data pad low through the open drain
   chk_data_pull: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_03]
      block_enable && !data_out_bit
      |-> port_b_line_five_oe && !port_b_line_five_out)
      else $error("data line not pulled low");

   // Condition two interrupt follows its status bit when enabled
   chk_rise_irq: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_08]
      $rose(irq_status[0]) && irq_enable[0] |-> irq)
      else $error("enabled interrupt two not raised");

   // No enabled status bit, no interrupt
   chk_irq_quiet: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_08]
      (irq_status & irq_enable) == 2'h0 |-> !irq)
      else $error("interrupt without enabled status");

   // Sample holds between clock rises
   chk_sample_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_13]
      clk_en && !(block_enable && clk_rise) |=> $stable(sampled_data_value))
      else $error("sample changed without clock rise");

   // Disabling the block drops the wait flag
   chk_wait_disable: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_11]
      clk_en && !block_enable && !stretch_evt |=> !stretch_active_flag)
      else $error("wait flag kept while disabled");

   // Low clock enable freezes flags and stretch state
   chk_freeze_hold: assert property (@(posedge sys_clk) disable iff (!rstn) // see [RULE_19]
      !clk_en
      |=> $stable(falling_condition_bit) && $stable(stretch_active_flag) && $stable(block_enable))
      else $error("state moved while frozen");
endmodule

// file: design/tlsa_pkg.sv
package tlsa_pkg;
   // Register indices (byte registers, one per address)
   localparam logic [3:0] ADDR_DATA_LINE   = 4'h0;
   localparam logic [3:0] ADDR_CLOCK_LINE  = 4'h1;
   localparam logic [3:0] ADDR_CONTROL     = 4'h2;
   localparam logic [3:0] ADDR_FALL_COND   = 4'h3;
   localparam logic [3:0] ADDR_RISE_COND   = 4'h4;
   localparam logic [3:0] ADDR_SAMPLED     = 4'h5;
   localparam logic [3:0] ADDR_EDGE_FLAG   = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STATUS  = 4'h7;
   localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'h8;
   localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'h9;
   // Control register fields
   localparam int CTRL_ENABLE_BIT  = 0;
   localparam int CTRL_UNCOND_BIT  = 1;
   localparam int CTRL_COND_BIT    = 2;
   localparam int CTRL_WAIT_BIT    = 3;
   // Interrupt status fields, top two bits of interrupt register layout
   localparam int IRQ_RISE_BIT     = 6;
   localparam int IRQ_FALL_BIT     = 7;
   // Reset values
   localparam logic       DRIVE_RESET  = 1'h1;
   localparam logic [2:0] CTRL_RESET   = 3'h0;
   localparam logic [7:0] IRQ_EN_RESET = 8'h00;
endpackage

// file: testbench/tlsa_core_tb.sv
`timescale 1ns/1ps
module tlsa_core_tb;
   import tlsa_pkg::*;
   // One ordinary case: optional write, then read back
   typedef struct packed {
      logic       do_wr;
      logic [3:0] addr;
      logic [7:0] wdata;
      logic [7:0] exp;
   } tlsa_row_t;
   // Clock, reset, register port
   logic       sys_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, rv;
   // Wires, design pin controls and peer pulls
   logic       clk_wire, data_wire, four_out, four_oe, five_out, five_oe, owns, irq;
   logic       clk_pull, data_pull;
   // Bookkeeping
   int         failures = 0, n_tests = 0, cycles = 0;
   // Pull-ups on both lines; any party pulling low wins
   assign clk_wire  = ~(four_oe | clk_pull);
   assign data_wire = ~(five_oe | data_pull);
   // System clock, 4 ns
   initial begin
      forever #2 sys_clk = ~sys_clk;
   end
   tlsa_core dut_u (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_b_line_four_in(clk_wire), .port_b_line_four_out(four_out),
      .port_b_line_four_oe(four_oe), .port_b_line_five_in(data_wire),
      .port_b_line_five_out(five_out), .port_b_line_five_oe(five_oe),
      .block_owns_pins(owns), .irq(irq));
   tlsa_peer peer_u (.clk_line(clk_wire), .clk_pull(clk_pull), .data_pull(data_pull));
   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr    <= 1'b0;
   endtask
   // One-cycle read strobe; data stand only in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp, input string what);
      rd(a, rv);
      chk(rv, exp, what);
   endtask
   // Peer clock bit that the design stretches; software ends the stretch
   task automatic stretched(input logic [7:0] ctrl);
      fork
         peer_u.clock_bit(1'b1);
         begin
            repeat (60) @(posedge sys_clk);
            chk({7'h0, clk_wire}, 8'h00, "clock held low");
            chk_rd(ADDR_CONTROL, ctrl | 8'h08, "wait flag set");
            wr(ADDR_SAMPLED, 8'h00);
            repeat (4) @(posedge sys_clk);
            chk({7'h0, clk_wire}, 8'h01, "clock released");
         end
      join
      chk_rd(ADDR_CONTROL, ctrl, "wait flag clear");
   endtask
   // Verdict
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Hang guard, well above the expected run
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         failures++;
         $display("mismatch at %0t: run did not finish", $time);
         results();
      end
   end
   // Ordinary register cases
   tlsa_row_t rows [14] = '{
      '{1'b0, ADDR_CONTROL,    8'h00, 8'h00},
      '{1'b0, ADDR_FALL_COND,  8'h00, 8'h00},
      '{1'b0, ADDR_EDGE_FLAG,  8'h00, 8'h00},
      '{1'b0, ADDR_IRQ_STATUS, 8'h00, 8'h00},
      '{1'b0, ADDR_DATA_LINE,  8'h00, 8'h01},
      '{1'b0, ADDR_CLOCK_LINE, 8'h00, 8'h01},
      '{1'b1, ADDR_CONTROL,    8'hf6, 8'h06},
      '{1'b1, ADDR_CONTROL,    8'h01, 8'h01},
      '{1'b1, ADDR_DATA_LINE,  8'h00, 8'h00},
      '{1'b1, ADDR_DATA_LINE,  8'hff, 8'h01},
      '{1'b1, ADDR_CLOCK_LINE, 8'h00, 8'h00},
      '{1'b1, ADDR_CLOCK_LINE, 8'hff, 8'h01},
      '{1'b1, 4'hf,            8'hff, 8'h00}, // unmapped index
      '{1'b1, ADDR_FALL_COND,  8'hff, 8'h00}
   };
   // Main sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         if (rows[i].do_wr) wr(rows[i].addr, rows[i].wdata);
         repeat (4) @(posedge sys_clk);
         chk_rd(rows[i].addr, rows[i].exp, "register row");
      end
      chk({7'h0, owns}, 8'h01, "pins owned");
      chk({6'h0, four_out, five_out}, 8'h00, "drive level");
      $display("register table done");
      // Own data writes with the clock high raised both conditions
      wr(ADDR_IRQ_ENABLE, 8'hc0);
      chk_rd(ADDR_IRQ_STATUS, 8'hc0, "own drive events");
      chk({7'h0, irq}, 8'h01, "irq raised");
      wr(ADDR_IRQ_CLEAR, 8'hff);
      wr(ADDR_RISE_COND, 8'h00);
      rd(ADDR_SAMPLED, rv);
      chk({7'h0, irq}, 8'h00, "irq cleared");
      // Peer frame: start mark, bits, stop mark
      peer_u.data_edge(1'b0);
      chk_rd(ADDR_FALL_COND, 8'h01, "falling condition");
      chk_rd(ADDR_IRQ_STATUS, 8'h80, "status falling");
      peer_u.clock_bit(1'b0);
      peer_u.clock_bit(1'b1);
      chk_rd(ADDR_EDGE_FLAG, 8'h01, "new sample");
      chk_rd(ADDR_SAMPLED, 8'h01, "sampled bit");
      chk_rd(ADDR_EDGE_FLAG, 8'h00, "sample taken");
      peer_u.clock_bit(1'b0);
      peer_u.data_edge(1'b1);
      chk_rd(ADDR_RISE_COND, 8'h01, "rising condition");
      chk_rd(ADDR_IRQ_STATUS, 8'hc0, "status both");
      wr(ADDR_FALL_COND, 8'h5a);
      chk_rd(ADDR_FALL_COND, 8'h00, "flag write clears");
      $display("frame events done");
      // Unconditional, then conditional stretching
      wr(ADDR_CONTROL, 8'h03);
      stretched(8'h03);
      wr(ADDR_CONTROL, 8'h05);
      peer_u.clock_bit(1'b1);
      chk_rd(ADDR_CONTROL, 8'h05, "no stretch unmarked");
      peer_u.data_edge(1'b0);
      stretched(8'h05);
      $display("stretching done");
      // Disabled block neither detects nor samples
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_FALL_COND, 8'h00);
      rd(ADDR_SAMPLED, rv);
      peer_u.data_edge(1'b1);
      peer_u.data_edge(1'b0);
      peer_u.clock_bit(1'b0);
      chk_rd(ADDR_FALL_COND, 8'h00, "detector off");
      chk_rd(ADDR_EDGE_FLAG, 8'h00, "sampler off");
      chk({7'h0, owns}, 8'h00, "pins returned");
      $display("disabled block done");
      // Reset in mid-run while the data line is driven low
      wr(ADDR_CONTROL, 8'h01);
      wr(ADDR_DATA_LINE, 8'h00);
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      #1 chk({6'h0, four_oe, five_oe}, 8'h00, "pins freed");
      chk_rd(ADDR_CONTROL, 8'h00, "control reset");
      wr(ADDR_CONTROL, 8'h01);
      repeat (2) @(posedge sys_clk);
      chk({7'h0, five_oe}, 8'h00, "data drive reset high");
      $display("mid-run reset done");
      // Frozen clock enable ignores a write
      @(posedge sys_clk);
      clk_en <= 1'b0;
      wr(ADDR_CONTROL, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b1;
      chk_rd(ADDR_CONTROL, 8'h01, "frozen write ignored");
      chk({7'h0, owns}, 8'h01, "pins kept while frozen");
      $display("freeze done");
      results();
   end
endmodule

// file: testbench/tlsa_peer.sv
`timescale 1ns/1ps
// Far-side peer: owns the link clock and pulls both lines low through open drain
module tlsa_peer (
   // Wire level of the clock line
   input  wire logic clk_line,
   // Pull-downs onto the wires, high pulls low
   output logic      clk_pull,
   output logic      data_pull
);
   // Lines released; the link clock stands still between frames
   initial begin
      clk_pull  = 1'b0;
      data_pull = 1'b0;
   end
   // Data edge while the clock line rests high (start or stop mark)
   task automatic data_edge(input logic v);
      data_pull = ~v;
      #80;
   endtask
   // One bit of 160 ns; data changes only while the clock is low
   task automatic clock_bit(input logic v);
      clk_pull = 1'b1;
      #40;
      data_pull = ~v;
      #40;
      clk_pull = 1'b0;
      // A stretched clock holds the peer, bounded wait
      for (int i = 0; i < 250 && clk_line !== 1'b1; i++) #4;
      #80;
   endtask
endmodule
